// [design/dims_top.sv]
`timescale 1ns/1ns
module dims_top #(
  parameter int SETTLE_CYC = dims_pkg::SELECT_SETTLE_CYC,
  parameter int TEACH_CYC  = dims_pkg::TEACH_HOLD_CYC,
  parameter int AW         = dims_pkg::ANALOG_W,
  parameter int PW         = dims_pkg::POS_W
) (
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire logic                        ce,
  input  wire logic                        select_bit0,
  input  wire logic                        select_bit1,
  input  wire logic                        select_bit2,
  input  wire logic                        select_bit3_or_jog_left,
  input  wire logic                        select_bit4_or_jog_right,
  input  wire logic                        start_teach_input,
  input  wire logic                        enable_input,
  input  wire logic                        stop_input,
  input  wire logic [dims_pkg::PIN_W-1:0]  invert_mask,
  input  wire dims_pkg::dims_mode_t        op_mode,
  input  wire logic                        ready_in,
  input  wire logic                        error_in,
  input  wire logic                        stroke_configured,
  input  wire logic                        homing_configured,
  input  wire logic                        move_done,
  input  wire logic                        standstill,
  input  wire logic                        prof_exists,
  input  wire dims_pkg::dims_kind_t        prof_kind,
  input  wire logic                        prof_chain_en,
  input  wire logic [dims_pkg::IDX_W-1:0]  prof_chain_next,
  input  wire logic [AW-1:0]               analog_position_input,
  input  wire logic [AW-1:0]               analog_velocity_input,
  input  wire logic [PW-1:0]               actual_position,
  input  wire logic                        goal_wr_en,
  input  wire logic [dims_pkg::IDX_W-1:0]  goal_wr_idx,
  input  wire logic [PW-1:0]               goal_wr_data,
  output logic      [dims_pkg::IDX_W-1:0]  prof_idx,
  output logic      [dims_pkg::NUM_W-1:0]  move_number,
  output logic                             launch,
  output logic                             active,
  output logic                             halt,
  output logic                             quick_stop,
  output logic                             motor_power,
  output logic                             jog_left,
  output logic                             jog_right,
  output logic      [PW-1:0]               goal_position,
  output logic      [AW-1:0]               vel_cmd,
  output logic                             dir_cmd,
  output logic      [AW-1:0]               pos_cmd,
  output logic                             refused,
  output logic                             teach_done
);
  import dims_pkg::*;

  localparam int NMOVES = 1 << IDX_W;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_sync;
  logic [PIN_W-1:0] pin_act;
  logic             tipp;
  logic [IDX_W-1:0] sel_idx;
  logic             settled;
  logic             start_act;
  logic             enable_act;
  logic             stop_act;
  logic             start_rise;
  logic             accept_ok;
  logic             req_ok;
  logic             analog_kind;
  logic             teach_wr;

  dims_state_t      state_reg;
  dims_state_t      state_next;
  logic [IDX_W-1:0] idx_reg;
  logic [IDX_W-1:0] idx_next;
  logic [TEACH_CW-1:0] hold_reg;
  logic [TEACH_CW-1:0] hold_next;
  logic             taught_reg;
  logic             taught_next;
  logic             start_q_reg;
  logic             start_q_next;
  logic             launch_reg;
  logic             launch_next;
  logic             refused_reg;
  logic             refused_next;
  logic             teach_done_reg;
  logic             power_reg;
  logic             power_next;
  logic             qstop_reg;
  logic             qstop_next;
  logic             jog_l_reg;
  logic             jog_l_next;
  logic             jog_r_reg;
  logic             jog_r_next;
  logic [AW-1:0]    vel_reg;
  logic [AW-1:0]    vel_next;
  logic             dir_reg;
  logic             dir_next;
  logic [AW-1:0]    pos_reg;
  logic [AW-1:0]    pos_next;
  logic [PW-1:0]    goal_reg;
  logic [PW-1:0]    goal_mem [NMOVES];

  // Profile index for the decoded select pattern
  function automatic logic [IDX_W-1:0] decode_sel(input logic is_tipp,
                                                  input logic [SEL_W-1:0] s);
    decode_sel = is_tipp ? {2'b00, s[TIPP_SEL_W-1:0]} : s;
  endfunction

  assign pin_raw = {stop_input, enable_input, start_teach_input,
                    select_bit4_or_jog_right, select_bit3_or_jog_left,
                    select_bit2, select_bit1, select_bit0};

  dims_sync #(
    .W   (PIN_W),
    .RST (PIN_RST)
  ) u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ce      (ce),
    .din     (pin_raw),
    .dout    (pin_sync)
  );

  assign pin_act    = pin_sync ^ invert_mask;
  assign tipp       = (op_mode == DIMS_MODE_TIPP);
  assign sel_idx    = decode_sel(tipp, pin_act[PIN_SEL0 +: SEL_W]);
  assign start_act  = pin_act[PIN_START];
  assign enable_act = pin_act[PIN_ENABLE];
  assign stop_act   = pin_act[PIN_STOP];
  assign start_rise = start_act && !start_q_reg;

  dims_settle #(
    .W   (IDX_W),
    .CW  (SETTLE_CW),
    .CYC (SETTLE_CYC)
  ) u_settle (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ce      (ce),
    .sel     (sel_idx),
    .settled (settled)
  );

  assign active      = (state_reg == DIMS_ST_CHECK) || (state_reg == DIMS_ST_RUN) ||
                       (state_reg == DIMS_ST_STOP);
  assign accept_ok   = enable_act && ready_in && !active && !error_in;
  assign analog_kind = (prof_kind == DIMS_ANALOG_VELOCITY_MODE) ||
                       (prof_kind == DIMS_ANALOG_VELOCITY_DIR) ||
                       (prof_kind == DIMS_ANALOG_TARGET_POSITION);
  assign req_ok = prof_exists && ready_in && !error_in &&
                  (stroke_configured || !((prof_kind == DIMS_GOAL_POSITION_MOVE) ||
                                          (prof_kind == DIMS_ANALOG_TARGET_POSITION))) &&
                  (homing_configured || (prof_kind != DIMS_REFERENCE_SEARCH));

  always_comb begin
    state_next   = state_reg;
    idx_next     = idx_reg;
    hold_next    = hold_reg;
    taught_next  = taught_reg;
    launch_next  = 1'b0;
    refused_next = 1'b0;
    teach_wr     = 1'b0;
    case (state_reg)
      DIMS_ST_IDLE: begin
        if (start_rise) begin
          if (accept_ok && settled) begin
            idx_next    = sel_idx;
            hold_next   = '0;
            taught_next = 1'b0;
            // Tipp mode waits for release: a held start may be a teach
            state_next  = tipp ? DIMS_ST_HOLD : DIMS_ST_CHECK;
          end else begin
            refused_next = 1'b1;
          end
        end
      end
      DIMS_ST_HOLD: begin
        if (!enable_act || stop_act) begin
          state_next = DIMS_ST_IDLE;
        end else if (start_act) begin
          if (hold_reg == TEACH_CW'(TEACH_CYC - 1) && !taught_reg) begin
            teach_wr     = prof_exists;
            refused_next = !prof_exists;
            taught_next  = 1'b1;
          end
          if (hold_reg != TEACH_CW'(TEACH_CYC - 1)) begin
            hold_next = hold_reg + TEACH_CW'(1);
          end
        end else begin
          state_next = taught_reg ? DIMS_ST_IDLE : DIMS_ST_CHECK;
        end
      end
      DIMS_ST_CHECK: begin
        if (!enable_act || stop_act) begin
          state_next = DIMS_ST_IDLE;
        end else if (req_ok) begin
          state_next  = DIMS_ST_RUN;
          launch_next = 1'b1;
        end else begin
          state_next   = DIMS_ST_IDLE;
          refused_next = 1'b1;
        end
      end
      DIMS_ST_RUN: begin
        if (!enable_act || stop_act) begin
          state_next = DIMS_ST_STOP;
        end else if (move_done && !analog_kind) begin
          if (prof_chain_en) begin
            idx_next   = prof_chain_next;
            state_next = DIMS_ST_CHECK;
          end else begin
            state_next = DIMS_ST_IDLE;
          end
        end
      end
      DIMS_ST_STOP: begin
        if (standstill) begin
          state_next = DIMS_ST_IDLE;
        end
      end
      default: state_next = DIMS_ST_IDLE;
    endcase
  end

  always_comb begin
    start_q_next = start_act;
    // Current stays on until the axis has come to rest
    power_next = enable_act ? 1'b1 : (standstill ? 1'b0 : power_reg);
    qstop_next = !enable_act && power_reg && !standstill;
    // Jog pins double as select bits; both pressed means no motion
    jog_l_next = tipp && (state_reg == DIMS_ST_IDLE) && accept_ok &&
                 pin_act[PIN_JOG_LEFT] && !pin_act[PIN_JOG_RIGHT];
    jog_r_next = tipp && (state_reg == DIMS_ST_IDLE) && accept_ok &&
                 pin_act[PIN_JOG_RIGHT] && !pin_act[PIN_JOG_LEFT];
    vel_next = '0;
    dir_next = 1'b0;
    pos_next = pos_reg;
    if (state_reg == DIMS_ST_RUN) begin
      if (prof_kind == DIMS_ANALOG_VELOCITY_MODE ||
          prof_kind == DIMS_ANALOG_VELOCITY_DIR) begin
        vel_next = analog_velocity_input;
        dir_next = (prof_kind == DIMS_ANALOG_VELOCITY_DIR) &&
                   analog_velocity_input[AW-1];
      end
      if (prof_kind == DIMS_ANALOG_TARGET_POSITION) begin
        pos_next = analog_position_input;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg      <= DIMS_ST_IDLE;
      idx_reg        <= '0;
      hold_reg       <= '0;
      taught_reg     <= 1'b0;
      // High so an inverted idle start cannot fake an edge
      start_q_reg    <= 1'b1;
      launch_reg     <= 1'b0;
      refused_reg    <= 1'b0;
      teach_done_reg <= 1'b0;
      power_reg      <= 1'b0;
      qstop_reg      <= 1'b0;
      jog_l_reg      <= 1'b0;
      jog_r_reg      <= 1'b0;
      vel_reg        <= '0;
      dir_reg        <= 1'b0;
      pos_reg        <= '0;
      goal_reg       <= '0;
    end else if (ce) begin
      state_reg      <= state_next;
      idx_reg        <= idx_next;
      hold_reg       <= hold_next;
      taught_reg     <= taught_next;
      start_q_reg    <= start_q_next;
      launch_reg     <= launch_next;
      refused_reg    <= refused_next;
      teach_done_reg <= teach_wr;
      power_reg      <= power_next;
      qstop_reg      <= qstop_next;
      jog_l_reg      <= jog_l_next;
      jog_r_reg      <= jog_r_next;
      vel_reg        <= vel_next;
      dir_reg        <= dir_next;
      pos_reg        <= pos_next;
      goal_reg       <= goal_mem[idx_reg];
    end
  end

  // Goal store; a teach beats a simultaneous profile write
  always_ff @(posedge sys_clk) begin
    if (ce && teach_wr) begin
      goal_mem[idx_reg] <= actual_position;
    end else if (ce && goal_wr_en) begin
      goal_mem[goal_wr_idx] <= goal_wr_data;
    end
  end

  assign prof_idx      = idx_reg;
  assign move_number   = {1'b0, idx_reg} + NUM_W'(1);
  assign launch        = launch_reg;
  assign halt          = (state_reg == DIMS_ST_STOP);
  assign quick_stop    = qstop_reg;
  assign motor_power   = power_reg;
  assign jog_left      = jog_l_reg;
  assign jog_right     = jog_r_reg;
  assign goal_position = goal_reg;
  assign vel_cmd       = vel_reg;
  assign dir_cmd       = dir_reg;
  assign pos_cmd       = pos_reg;
  assign refused       = refused_reg;
  assign teach_done    = teach_done_reg;

  default clocking cb @(posedge sys_clk iff ce);
  endclocking
  default disable iff (!nrst);

  a_binary_select: assert property (
    (state_reg == DIMS_ST_IDLE && start_rise && accept_ok && settled && !tipp)
    |=> idx_reg == $past(pin_act[4:0]))
    else $error("binary selection not latched");
  a_tipp_select: assert property (
    (state_reg == DIMS_ST_IDLE && start_rise && accept_ok && settled && tipp)
    |=> idx_reg == {2'b00, $past(pin_act[2:0])} && state_reg == DIMS_ST_HOLD)
    else $error("tipp selection not latched");
  a_launch_origin: assert property (
    launch_reg |-> $past(state_reg) == DIMS_ST_CHECK && state_reg == DIMS_ST_RUN)
    else $error("launch without check");
  a_unsettled_refused: assert property (
    (state_reg == DIMS_ST_IDLE && start_rise && !settled) |=> state_reg == DIMS_ST_IDLE
    ##0 refused_reg)
    else $error("start accepted before settle");
  a_stop_halts: assert property (
    (state_reg == DIMS_ST_RUN && stop_act) |=> halt)
    else $error("stop did not halt");
  a_launch_gated: assert property (
    launch_reg |-> $past(enable_act && ready_in && !error_in && prof_exists))
    else $error("launch while not permitted");
  a_quick_stop_power: assert property (
    (!enable_act && power_reg && !standstill) |=> power_reg && quick_stop)
    else $error("current dropped before standstill");
  a_teach_store: assert property (
    teach_wr |=> goal_mem[$past(idx_reg)] == $past(actual_position) && teach_done)
    else $error("teach did not store position");
  a_single_launch: assert property (
    launch_reg |=> !launch_reg [*2])
    else $error("start launched twice");
  a_jog_mode: assert property (
    (jog_left || jog_right) |-> $past(tipp && enable_act) && !(jog_left && jog_right))
    else $error("jog outside tipp mode");

  c_launch: cover property (launch_reg);
  c_teach: cover property (teach_wr);
  c_chain: cover property (state_reg == DIMS_ST_RUN ##1 state_reg == DIMS_ST_CHECK);
  c_quick_stop: cover property (quick_stop ##1 !motor_power);
endmodule // dims_top

// [design/dims_pkg.sv]
package dims_pkg;
  localparam int SEL_W             = 5;
  localparam int IDX_W             = 5;
  localparam int NUM_W             = 6;
  localparam int TIPP_SEL_W        = 3;
  localparam int PIN_W             = 8;
  localparam int PIN_SEL0          = 0;
  localparam int PIN_JOG_LEFT      = 3;
  localparam int PIN_JOG_RIGHT     = 4;
  localparam int PIN_START         = 5;
  localparam int PIN_ENABLE        = 6;
  localparam int PIN_STOP          = 7;
  localparam logic [7:0] PIN_RST   = 8'h00;
  localparam int CLK_HZ            = 10_000_000;
  localparam int SELECT_SETTLE_MS  = 10;
  localparam int SELECT_SETTLE_CYC = SELECT_SETTLE_MS * (CLK_HZ / 1000);
  localparam int SETTLE_CW         = 17;
  localparam int TEACH_HOLD_S      = 5;
  localparam int TEACH_HOLD_CYC    = TEACH_HOLD_S * CLK_HZ;
  localparam int TEACH_CW          = 26;
  localparam int ANALOG_W          = 12;
  localparam int POS_W             = 32;

  typedef enum logic [0:0] {
    DIMS_MODE_BINARY = 1'b0,
    DIMS_MODE_TIPP   = 1'b1
  } dims_mode_t;

  typedef enum logic [2:0] {
    DIMS_REFERENCE_SEARCH      = 3'b000,
    DIMS_OFFSET_MOVE           = 3'b001,
    DIMS_GOAL_POSITION_MOVE    = 3'b010,
    DIMS_CONTINUOUS_SPIN       = 3'b011,
    DIMS_ANALOG_VELOCITY_MODE  = 3'b100,
    DIMS_ANALOG_VELOCITY_DIR   = 3'b101,
    DIMS_ANALOG_TARGET_POSITION = 3'b110
  } dims_kind_t;

  typedef enum logic [2:0] {
    DIMS_ST_IDLE  = 3'b000,
    DIMS_ST_HOLD  = 3'b001,
    DIMS_ST_CHECK = 3'b010,
    DIMS_ST_RUN   = 3'b011,
    DIMS_ST_STOP  = 3'b100
  } dims_state_t;
endpackage

// [design/dims_sync.sv]
`timescale 1ns/1ns
module dims_sync #(
  parameter int         W   = 8,
  parameter logic [7:0] RST = 8'h00
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = ce ? din : meta_reg;
    sync_next = ce ? meta_reg : sync_reg;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= RST[W-1:0];
      sync_reg <= RST[W-1:0];
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg;
endmodule // dims_sync

// [design/dims_settle.sv]
`timescale 1ns/1ns
module dims_settle #(
  parameter int W   = 5,
  parameter int CW  = 17,
  parameter int CYC = 100000
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] sel,
  output logic              settled
);
  logic [W-1:0]  sel_reg;
  logic [W-1:0]  sel_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // Any change restarts the wait, so glitches never latch
  always_comb begin
    sel_next = sel_reg;
    cnt_next = cnt_reg;
    if (ce) begin
      sel_next = sel;
      if (sel != sel_reg) begin
        cnt_next = '0;
      end else if (cnt_reg != CW'(CYC)) begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sel_reg <= '0;
      cnt_reg <= '0;
    end else begin
      sel_reg <= sel_next;
      cnt_reg <= cnt_next;
    end
  end

  assign settled = (cnt_reg == CW'(CYC));
endmodule // dims_settle

// [sim/dims_motion_model.sv]
`timescale 1ns/1ns
module dims_motion_model #(
  parameter int MOVE_CYC = 12
) (
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  input  wire logic [dims_pkg::IDX_W-1:0] prof_idx,
  input  wire logic                       launch,
  input  wire logic                       halt,
  input  wire logic                       quick_stop,
  output logic                            prof_exists,
  output dims_pkg::dims_kind_t            prof_kind,
  output logic                            prof_chain_en,
  output logic      [dims_pkg::IDX_W-1:0] prof_chain_next,
  output logic                            move_done,
  output logic                            standstill
);
  import dims_pkg::*;
  logic [7:0] cnt_reg;
  logic       stopping_reg;
  always_comb begin
    prof_exists = 1'b1;
    prof_chain_en = 1'b0;
    prof_chain_next = 5'h03;
    case (prof_idx)
      5'h00: prof_kind = DIMS_REFERENCE_SEARCH;
      5'h02: begin
        prof_kind = DIMS_OFFSET_MOVE;
        prof_chain_en = 1'b1;
      end
      5'h03: prof_kind = DIMS_OFFSET_MOVE;
      5'h04: prof_kind = DIMS_ANALOG_VELOCITY_DIR;
      5'h05: prof_kind = DIMS_ANALOG_TARGET_POSITION;
      5'h08: prof_kind = DIMS_ANALOG_VELOCITY_MODE;
      5'h07: begin
        prof_kind = DIMS_CONTINUOUS_SPIN;
        prof_exists = 1'b0;
      end
      default: prof_kind = DIMS_GOAL_POSITION_MOVE;
    endcase
  end
  // Analog moves never finish by themselves, only a stop ends them
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 8'h00;
      stopping_reg <= 1'b0;
      move_done <= 1'b0;
    end else begin
      move_done <= 1'b0;
      if (launch) begin
        cnt_reg <= 8'(MOVE_CYC);
        stopping_reg <= 1'b0;
      end else if ((halt || quick_stop) && cnt_reg != 8'h00 && !stopping_reg) begin
        cnt_reg <= 8'h03;
        stopping_reg <= 1'b1;
      end else if (cnt_reg == 8'h01 && !stopping_reg) begin
        cnt_reg <= 8'h00;
        move_done <= 1'b1;
      end else if (cnt_reg != 8'h00 && (stopping_reg || !prof_kind[2])) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
  assign standstill = (cnt_reg == 8'h00);
endmodule // dims_motion_model

// [sim/discrete_io_move_select_test.sv]
`timescale 1ns/1ns
module discrete_io_move_select_test;
  import dims_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  act = 8'h40;
  logic [7:0]  invert_mask = 8'h00;
  dims_mode_t  op_mode = DIMS_MODE_BINARY;
  logic        ready_in = 1'b1;
  logic        error_in = 1'b0;
  logic        stroke_configured = 1'b1;
  logic        homing_configured = 1'b1;
  logic [11:0] analog_position_input = 12'h000;
  logic [11:0] analog_velocity_input = 12'h000;
  logic        goal_wr_en = 1'b0;
  logic [4:0]  goal_wr_idx = 5'h00;
  logic [31:0] goal_wr_data = 32'h0;
  logic [31:0] actual_position = 32'h0000_1234;
  logic        move_done, standstill, prof_exists, prof_chain_en;
  dims_kind_t  prof_kind;
  logic [4:0]  prof_idx, prof_chain_next;
  logic [5:0]  move_number;
  logic        launch, active, halt, quick_stop, motor_power, jog_left, jog_right;
  logic        dir_cmd, refused, teach_done;
  logic [31:0] goal_position;
  logic [11:0] vel_cmd, pos_cmd;
  int          mismatches = 0;
  int          total_checks = 0;
  // Pins carry active levels through the inversion mask
  wire  [7:0]  pin = act ^ invert_mask;
  wire  [5:0]  ev = {quick_stop, ~active, teach_done, refused, halt, launch};
  always #50 sys_clk = ~sys_clk;
  dims_top #(.SETTLE_CYC(20), .TEACH_CYC(40)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .ce(1'b1),
    .select_bit0(pin[0]), .select_bit1(pin[1]), .select_bit2(pin[2]),
    .select_bit3_or_jog_left(pin[3]), .select_bit4_or_jog_right(pin[4]),
    .start_teach_input(pin[5]), .enable_input(pin[6]), .stop_input(pin[7]),
    .invert_mask(invert_mask), .op_mode(op_mode), .ready_in(ready_in),
    .error_in(error_in), .stroke_configured(stroke_configured),
    .homing_configured(homing_configured), .move_done(move_done),
    .standstill(standstill), .prof_exists(prof_exists), .prof_kind(prof_kind),
    .prof_chain_en(prof_chain_en), .prof_chain_next(prof_chain_next),
    .analog_position_input(analog_position_input),
    .analog_velocity_input(analog_velocity_input), .actual_position(actual_position),
    .goal_wr_en(goal_wr_en), .goal_wr_idx(goal_wr_idx), .goal_wr_data(goal_wr_data),
    .prof_idx(prof_idx), .move_number(move_number), .launch(launch), .active(active),
    .halt(halt), .quick_stop(quick_stop), .motor_power(motor_power),
    .jog_left(jog_left), .jog_right(jog_right), .goal_position(goal_position),
    .vel_cmd(vel_cmd), .dir_cmd(dir_cmd), .pos_cmd(pos_cmd), .refused(refused),
    .teach_done(teach_done));
  dims_motion_model far (
    .sys_clk(sys_clk), .nrst(nrst), .prof_idx(prof_idx), .launch(launch),
    .halt(halt), .quick_stop(quick_stop), .prof_exists(prof_exists),
    .prof_kind(prof_kind), .prof_chain_en(prof_chain_en),
    .prof_chain_next(prof_chain_next), .move_done(move_done), .standstill(standstill));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    chk(32'(seen), 32'(exp));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wt(input int b);
    for (int i = 0; i < 200 && ev[b] !== 1'b1; i++) @(negedge sys_clk);
  endtask
  // Selection held past the settle time, then start raised
  task automatic go(input logic [4:0] s);
    act[5] = 1'b0;
    act[4:0] = s;
    cyc(30);
    act[5] = 1'b1;
  endtask
  task automatic binary_sel;
    logic [4:0] v [3] = '{5'h00, 5'h01, 5'h1f};
    foreach (v[i]) begin
      go(v[i]);
      wt(0);
      chk(32'(move_number), 32'(v[i]) + 32'h1);
      chk(32'(prof_idx), 32'(v[i]));
      wt(4);
    end
  endtask
  task automatic inverted_stop;
    invert_mask = 8'hc1;
    cyc(10);
    go(5'h01);
    wt(0);
    chk(32'(move_number), 32'h2);
    act[7] = 1'b1;
    wt(1);
    chk1(halt, 1'b1);
    act[7] = 1'b0;
    wt(4);
    chk1(active, 1'b0);
    invert_mask = 8'h00;
    cyc(10);
  endtask
  task automatic chain_run;
    go(5'h02);
    wt(0);
    cyc(1);
    wt(0);
    chk1(launch, 1'b1);
    chk(32'(prof_idx), 32'h3);
    wt(4);
  endtask
  task automatic refusals;
    act[5] = 1'b0;
    act[4:0] = 5'h03;
    cyc(3);
    act[5] = 1'b1;
    wt(2);
    chk1(refused, 1'b1);
    for (int k = 0; k < 5; k++) begin
      error_in = (k == 0);
      ready_in = (k != 1);
      homing_configured = (k != 2);
      stroke_configured = (k != 3);
      go(k == 2 ? 5'h00 : (k == 4 ? 5'h07 : 5'h01));
      wt(2);
      chk1(refused, 1'b1);
      chk1(launch, 1'b0);
    end
    {error_in, ready_in, homing_configured, stroke_configured} = 4'b0111;
  endtask
  task automatic analog_run;
    analog_velocity_input = 12'h000;
    go(5'h04);
    wt(0);
    analog_velocity_input = 12'hf80;
    cyc(4);
    chk(32'(vel_cmd), 32'hf80);
    chk1(dir_cmd, 1'b1);
    act[7] = 1'b1;
    wt(1);
    chk1(halt, 1'b1);
    act[7] = 1'b0;
    wt(4);
    analog_velocity_input = 12'h000;
    go(5'h08);
    wt(0);
    analog_velocity_input = 12'hf80;
    cyc(4);
    chk(32'(vel_cmd), 32'hf80);
    chk1(dir_cmd, 1'b0);
    act[7] = 1'b1;
    wt(1);
    act[7] = 1'b0;
    wt(4);
    chk(32'(vel_cmd), 32'h0);
    analog_position_input = 12'h000;
    go(5'h05);
    wt(0);
    analog_position_input = 12'h3a5;
    cyc(4);
    chk(32'(pos_cmd), 32'h3a5);
    act[6] = 1'b0;
    wt(5);
    chk1(quick_stop, 1'b1);
    chk1(motor_power, 1'b1);
    wt(4);
    cyc(3);
    chk1(motor_power, 1'b0);
    go(5'h03);
    wt(2);
    chk1(refused, 1'b1);
    act[6] = 1'b1;
    cyc(5);
  endtask
  task automatic tipp_run;
    op_mode = DIMS_MODE_TIPP;
    go(5'h1e);
    cyc(3);
    act[5] = 1'b0;
    wt(0);
    chk(32'(move_number), 32'h7);
    wt(4);
    goal_wr_idx = 5'h06;
    goal_wr_data = 32'h5555;
    goal_wr_en = 1'b1;
    cyc(1);
    goal_wr_en = 1'b0;
    cyc(1);
    chk(goal_position, 32'h0000_5555);
    go(5'h1e);
    wt(3);
    chk1(teach_done, 1'b1);
    act[5] = 1'b0;
    cyc(6);
    chk(goal_position, 32'h0000_1234);
    go(5'h07);
    wt(2);
    chk1(refused, 1'b1);
    chk1(teach_done, 1'b0);
    act[5] = 1'b0;
    cyc(6);
    act[4:0] = 5'h08;
    cyc(6);
    chk1(jog_left, 1'b1);
    chk1(jog_right, 1'b0);
    act[4:0] = 5'h00;
    cyc(6);
    chk1(jog_left, 1'b0);
    op_mode = DIMS_MODE_BINARY;
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    cyc(5);
    nrst = 1'b1;
    cyc(5);
    binary_sel();
    inverted_stop();
    chain_run();
    refusals();
    analog_run();
    tipp_run();
    report_and_stop();
  end
endmodule // discrete_io_move_select_test
